//--- pwc_consts.vh
// Constants of the power mode clock controller: offsets, fields, resets, codes
`ifndef PWC_CONSTS_VH
`define PWC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PWC_OFF_CLK0      5'h00
`define PWC_OFF_CLK1      5'h04
`define PWC_OFF_CLK2      5'h08
`define PWC_OFF_PLL       5'h0c
`define PWC_OFF_AUX       5'h10
`define PWC_OFF_STAT      5'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PWC_B_SUB_SEL     7
`define PWC_B_DIV8        6
`define PWC_B_MAIN_OFF    5
`define PWC_B_SUB_EN      4
`define PWC_B_PSTOP       2
`define PWC_B_DIV_HI      7
`define PWC_B_DIV_LO      6
`define PWC_B_PLL_SEL     1
`define PWC_B_ROC_SEL     1
`define PWC_B_PLL_RUN     7
`define PWC_B_PLL_X4      0
`define PWC_B_WDT_SRC     7
`define PWC_B_IN_WAIT     3
`define PWC_B_REFUSED     4

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define PWC_MASK_CLK0     8'hf4
`define PWC_MASK_CLK1     8'hc2
`define PWC_MASK_CLK2     8'h02
`define PWC_MASK_PLL      8'h81
`define PWC_MASK_AUX      8'h8f
`define PWC_RST_CLK0      8'h00
`define PWC_RST_CLK1      8'hc0
`define PWC_RST_CLK2      8'h02
`define PWC_RST_PLL       8'h00
`define PWC_RST_AUX       8'h00

// ----------------------------------------------------------------
// Operating modes, clock sources and divider codes
// ----------------------------------------------------------------
`define PWC_M_PLL         3'h0
`define PWC_M_HIGH        3'h1
`define PWC_M_MED         3'h2
`define PWC_M_LOWSPD      3'h3
`define PWC_M_LOWPOW      3'h4
`define PWC_M_ROC         3'h5
`define PWC_M_ROCLP       3'h6
`define PWC_S_MAIN        2'h0
`define PWC_S_SUB         2'h1
`define PWC_S_PLL         2'h2
`define PWC_S_ROC         2'h3
`define PWC_D_1           3'h0
`define PWC_D_2           3'h1
`define PWC_D_4           3'h2
`define PWC_D_8           3'h3
`define PWC_D_16          3'h4

`endif

//--- pwc_power_mode_clock_control.v
// Power mode clock controller: mode registers, clock selection, wait mode gating
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_consts.vh"

module pwc_power_mode_clock_control (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [4:0]   avs_address,
    input  wire         avs_read,
    input  wire         avs_write,
    input  wire [31:0]  avs_writedata,
    input  wire [3:0]   avs_byteenable,
    output reg  [31:0]  avs_readdata,
    output reg          avs_waitrequest,
    input  wire         main_clk_in,
    input  wire         sub_clk_in,
    input  wire         pll_clk_in,
    input  wire         onchip_clk_in,
    input  wire         wait_exec,
    input  wire         wake_req,
    output reg          cpu_clk_q,
    output reg          wdt_clk_q,
    output reg          cpu_halt_q,
    output reg          io_hold_q,
    output reg          main_osc_en_q,
    output reg          sub_osc_en_q,
    output reg          onchip_osc_en_q,
    output reg          pll_en_q,
    output reg          pll_mult4_q,
    output reg  [3:0]   onchip_freq_q,
    output reg  [3:0]   periph_clk_q,
    output reg          serial_clock_div1,
    output reg          serial_clock_div32,
    output reg          converter_clock,
    output reg          subclk_timer_source
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [7:0]  clk0_q;
    reg  [7:0]  clk1_q;
    reg  [7:0]  clk2_q;
    reg  [7:0]  pll_q;
    reg  [7:0]  aux_q;
    reg         in_wait_q;
    reg         refused_q;
    reg  [3:0]  src_m1_q;
    reg  [3:0]  src_s_q;
    reg  [3:0]  src_p_q;
    reg  [3:0]  mcnt_q;
    reg  [3:0]  rcnt_q;
    reg  [4:0]  pcnt_q;
    reg  [4:0]  sel_act_q;
    reg         parked_q;
    reg  [6:0]  pgate_q;
    reg  [6:0]  pout_q;
    reg  [7:0]  c0_w;
    reg  [7:0]  c1_w;
    reg  [7:0]  c2_w;
    reg  [2:0]  mode_w;
    reg         legal_w;
    reg         wr_hit_w;
    reg  [7:0]  rd_w;
    wire        acc_done;
    wire [2:0]  mode;
    wire [4:0]  sel_req;
    wire        main_s;
    wire        sub_s;
    wire        pll_s;
    wire        roc_s;
    wire        psrc_w;
    wire        prise_w;
    wire        cand_act;
    wire        cand_req;
    wire [6:0]  pbase;
    wire        pen;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Operating mode decoded from the three control registers
    function [2:0] mode_of;
        input [7:0] a;
        input [7:0] b;
        input [7:0] c;
        begin
            if (b[`PWC_B_PLL_SEL])
                mode_of = `PWC_M_PLL;
            else if (a[`PWC_B_SUB_SEL])
                mode_of = a[`PWC_B_MAIN_OFF] ? `PWC_M_LOWPOW : `PWC_M_LOWSPD;
            else if (c[`PWC_B_ROC_SEL])
                mode_of = a[`PWC_B_MAIN_OFF] ? `PWC_M_ROCLP : `PWC_M_ROC;
            else if (!a[`PWC_B_DIV8] && b[`PWC_B_DIV_HI:`PWC_B_DIV_LO] == 2'h0)
                mode_of = `PWC_M_HIGH;
            else
                mode_of = `PWC_M_MED;
        end
    endfunction

    // Divider code from the separate bit and the two-bit field
    function [2:0] div_of;
        input       d8;
        input [1:0] f;
        begin
            if (d8)
                div_of = `PWC_D_8;
            else begin
                case (f)
                    2'h0:    div_of = `PWC_D_1;
                    2'h1:    div_of = `PWC_D_2;
                    2'h2:    div_of = `PWC_D_4;
                    default: div_of = `PWC_D_16;
                endcase
            end
        end
    endfunction

    // Clock level for a {source, divider} selection
    function cand_of;
        input [4:0] s;
        input [4:0] mv;
        input [4:0] rv;
        input       sb;
        input       pl;
        begin
            case (s[4:3])
                `PWC_S_MAIN: cand_of = mv[s[2:0]];
                `PWC_S_SUB:  cand_of = sb;
                `PWC_S_PLL:  cand_of = pl;
                default:     cand_of = rv[s[2:0]];
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Write decode and transition check
    // ----------------------------------------------------------------
    assign acc_done = (avs_read | avs_write) & ~avs_waitrequest;
    assign mode     = mode_of(clk0_q, clk1_q, clk2_q);

    // Prospective register contents and whether the move is allowed
    always @* begin
        c0_w     = clk0_q;
        c1_w     = clk1_q;
        c2_w     = clk2_q;
        wr_hit_w = acc_done & avs_write & avs_byteenable[0];
        if (wr_hit_w && avs_address == `PWC_OFF_CLK0)
            c0_w = avs_writedata[7:0] & `PWC_MASK_CLK0;
        if (wr_hit_w && avs_address == `PWC_OFF_CLK1)
            c1_w = avs_writedata[7:0] & `PWC_MASK_CLK1;
        if (wr_hit_w && avs_address == `PWC_OFF_CLK2)
            c2_w = avs_writedata[7:0] & `PWC_MASK_CLK2;
        mode_w = mode_of(c0_w, c1_w, c2_w);
        if (mode_w == `PWC_M_LOWPOW)
            c0_w[`PWC_B_DIV8] = 1'b1;
        legal_w = 1'b1;
        if (mode == `PWC_M_LOWPOW && (mode_w == `PWC_M_ROC || mode_w == `PWC_M_ROCLP))
            legal_w = 1'b0;
        if ((mode == `PWC_M_ROC || mode == `PWC_M_ROCLP) && mode_w == `PWC_M_LOWPOW)
            legal_w = 1'b0;
        if (mode_w == `PWC_M_PLL && mode != `PWC_M_PLL && mode != `PWC_M_HIGH)
            legal_w = 1'b0;
        if (mode_w == `PWC_M_LOWPOW && mode != `PWC_M_LOWPOW && mode != `PWC_M_LOWSPD)
            legal_w = 1'b0;
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Control registers; a refused write leaves the mode bits as they were
    always @(posedge clk_sys) begin
        if (rst) begin
            clk0_q    <= `PWC_RST_CLK0;
            clk1_q    <= `PWC_RST_CLK1;
            clk2_q    <= `PWC_RST_CLK2;
            pll_q     <= `PWC_RST_PLL;
            aux_q     <= `PWC_RST_AUX;
            refused_q <= 1'b0;
        end else begin
            if (wr_hit_w && (avs_address == `PWC_OFF_CLK0 ||
                             avs_address == `PWC_OFF_CLK1 ||
                             avs_address == `PWC_OFF_CLK2)) begin
                refused_q <= ~legal_w;
                if (legal_w) begin
                    clk0_q <= c0_w;
                    clk1_q <= c1_w;
                    clk2_q <= c2_w;
                end
            end
            if (wr_hit_w && avs_address == `PWC_OFF_PLL)
                pll_q <= avs_writedata[7:0] & `PWC_MASK_PLL;
            if (wr_hit_w && avs_address == `PWC_OFF_AUX)
                aux_q <= avs_writedata[7:0] & `PWC_MASK_AUX;
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always @* begin
        case (avs_address)
            `PWC_OFF_CLK0: rd_w = clk0_q;
            `PWC_OFF_CLK1: rd_w = clk1_q;
            `PWC_OFF_CLK2: rd_w = clk2_q;
            `PWC_OFF_PLL:  rd_w = pll_q;
            `PWC_OFF_AUX:  rd_w = aux_q;
            `PWC_OFF_STAT: rd_w = {3'h0, refused_q, in_wait_q, mode};
            default:       rd_w = 8'h00;
        endcase
    end

    // Bus handshake: one wait cycle, then the access completes
    always @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (acc_done) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read | avs_write) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h00_0000, rd_w};
        end
    end

    // ----------------------------------------------------------------
    // Wait mode
    // ----------------------------------------------------------------
    // Wait entry on the instruction strobe outside PLL mode, exit on a wake request
    always @(posedge clk_sys) begin
        if (rst) begin
            in_wait_q <= 1'b0;
        end else if (in_wait_q) begin
            if (wake_req)
                in_wait_q <= 1'b0;
        end else if (wait_exec && mode != `PWC_M_PLL) begin
            in_wait_q <= 1'b1;
        end
    end

    // Halt and pin hold follow the wait state
    always @(posedge clk_sys) begin
        if (rst) begin
            cpu_halt_q <= 1'b0;
            io_hold_q  <= 1'b0;
        end else begin
            cpu_halt_q <= in_wait_q;
            io_hold_q  <= in_wait_q;
        end
    end

    // ----------------------------------------------------------------
    // Oscillator controls
    // ----------------------------------------------------------------
    // Enables depend only on the control bits, never on wait
    always @(posedge clk_sys) begin
        if (rst) begin
            main_osc_en_q   <= 1'b1;
            sub_osc_en_q    <= 1'b0;
            onchip_osc_en_q <= 1'b1;
            pll_en_q        <= 1'b0;
            pll_mult4_q     <= 1'b0;
            onchip_freq_q   <= 4'h0;
        end else begin
            main_osc_en_q   <= ~clk0_q[`PWC_B_MAIN_OFF];
            sub_osc_en_q    <= clk0_q[`PWC_B_SUB_EN];
            onchip_osc_en_q <= clk2_q[`PWC_B_ROC_SEL] | aux_q[`PWC_B_WDT_SRC];
            pll_en_q        <= pll_q[`PWC_B_PLL_RUN];
            pll_mult4_q     <= pll_q[`PWC_B_PLL_X4];
            onchip_freq_q   <= aux_q[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Source sampling and dividers
    // ----------------------------------------------------------------
    // Two-stage synchronisers; src_p_q keeps the previous level
    always @(posedge clk_sys) begin
        if (rst) begin
            src_m1_q <= 4'h0;
            src_s_q  <= 4'h0;
            src_p_q  <= 4'h0;
        end else begin
            src_m1_q <= {onchip_clk_in, pll_clk_in, sub_clk_in, main_clk_in};
            src_s_q  <= src_m1_q;
            src_p_q  <= src_s_q;
        end
    end

    assign main_s = src_s_q[0];
    assign sub_s  = src_s_q[1];
    assign pll_s  = src_s_q[2];
    assign roc_s  = src_s_q[3];

    // Ripple counters advance on each rising edge of their source
    always @(posedge clk_sys) begin
        if (rst) begin
            mcnt_q <= 4'h0;
            rcnt_q <= 4'h0;
            pcnt_q <= 5'h00;
        end else begin
            if (main_s && !src_p_q[0])
                mcnt_q <= mcnt_q + 4'h1;
            if (roc_s && !src_p_q[3])
                rcnt_q <= rcnt_q + 4'h1;
            if (prise_w)
                pcnt_q <= pcnt_q + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Processor clock selection
    // ----------------------------------------------------------------
    // Requested source and divider for the current mode
    assign sel_req = (mode == `PWC_M_PLL) ? {`PWC_S_PLL, `PWC_D_1} :
                     (mode == `PWC_M_LOWSPD || mode == `PWC_M_LOWPOW) ?
                     {`PWC_S_SUB, `PWC_D_1} :
                     (mode == `PWC_M_ROC || mode == `PWC_M_ROCLP) ?
                     {`PWC_S_ROC, div_of(clk0_q[`PWC_B_DIV8], clk1_q[7:6])} :
                     {`PWC_S_MAIN, div_of(clk0_q[`PWC_B_DIV8], clk1_q[7:6])};

    assign cand_act = cand_of(sel_act_q, {mcnt_q, main_s}, {rcnt_q, roc_s}, sub_s, pll_s);
    assign cand_req = cand_of(sel_req, {mcnt_q, main_s}, {rcnt_q, roc_s}, sub_s, pll_s);

    // Park low on the old clock's low phase, resume on the new one's low phase
    always @(posedge clk_sys) begin
        if (rst) begin
            sel_act_q <= {`PWC_S_ROC, `PWC_D_16};
            parked_q  <= 1'b0;
        end else if (parked_q) begin
            if (!cand_act)
                parked_q <= 1'b0;
        end else if (sel_req != sel_act_q && !cand_act) begin
            sel_act_q <= sel_req;
            parked_q  <= 1'b1;
        end
    end

    // Processor and watchdog clocks; the processor clock stops in wait
    always @(posedge clk_sys) begin
        if (rst) begin
            cpu_clk_q <= 1'b0;
            wdt_clk_q <= 1'b0;
        end else begin
            cpu_clk_q <= ~parked_q & ~in_wait_q & cand_act;
            wdt_clk_q <= aux_q[`PWC_B_WDT_SRC] ? roc_s : (~parked_q & ~in_wait_q & cand_act);
        end
    end

    // ----------------------------------------------------------------
    // Peripheral clocks
    // ----------------------------------------------------------------
    // Peripheral source: PLL, on-chip oscillator or main clock
    assign psrc_w = (mode == `PWC_M_PLL) ? pll_s :
                    (mode == `PWC_M_ROC || mode == `PWC_M_ROCLP ||
                     (mode == `PWC_M_LOWSPD && clk2_q[`PWC_B_ROC_SEL])) ? roc_s : main_s;
    assign prise_w = (mode == `PWC_M_PLL) ? (pll_s & ~src_p_q[2]) :
                     (mode == `PWC_M_ROC || mode == `PWC_M_ROCLP ||
                      (mode == `PWC_M_LOWSPD && clk2_q[`PWC_B_ROC_SEL])) ?
                     (roc_s & ~src_p_q[3]) : (main_s & ~src_p_q[0]);

    // Converter, serial /32, serial /1, f32, f8, f2, f1
    assign pbase = {psrc_w, pcnt_q[4], psrc_w, pcnt_q[4], pcnt_q[2], pcnt_q[0], psrc_w};
    assign pen   = (mode != `PWC_M_LOWPOW) & ~(in_wait_q & clk0_q[`PWC_B_PSTOP]);

    // Each gate changes only while its clock is low, so no runt pulse leaks
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_pclk
            always @(posedge clk_sys) begin
                if (rst) begin
                    pgate_q[gi] <= 1'b0;
                    pout_q[gi]  <= 1'b0;
                end else begin
                    if (!pbase[gi])
                        pgate_q[gi] <= pen;
                    pout_q[gi] <= pgate_q[gi] & pbase[gi];
                end
            end
        end
    endgenerate

    // Output registers of the peripheral clocks and the sub timer source
    always @(posedge clk_sys) begin
        if (rst) begin
            periph_clk_q        <= 4'h0;
            serial_clock_div1   <= 1'b0;
            serial_clock_div32  <= 1'b0;
            converter_clock     <= 1'b0;
            subclk_timer_source <= 1'b0;
        end else begin
            periph_clk_q        <= pout_q[3:0];
            serial_clock_div1   <= pout_q[4];
            serial_clock_div32  <= pout_q[5];
            converter_clock     <= pout_q[6];
            subclk_timer_source <= clk0_q[`PWC_B_SUB_EN] & sub_s;
        end
    end

endmodule
`default_nettype wire

//--- pwc_power_mode_clock_control_assertions.sv
// Port-level checker of the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
module pwc_checker (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       wait_exec,
    input wire logic       cpu_clk_q,
    input wire logic       cpu_halt_q,
    input wire logic       io_hold_q,
    input wire logic       main_osc_en_q,
    input wire logic       sub_osc_en_q,
    input wire logic       onchip_osc_en_q,
    input wire logic       pll_en_q,
    input wire logic [3:0] onchip_freq_q,
    input wire logic       subclk_timer_source
);
    logic [7:0] stall_q;
    logic       clk_prev_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Cycles since the processor clock last changed level outside wait
    always_ff @(posedge clk_sys) begin
        clk_prev_q <= cpu_clk_q;
        if (rst || cpu_halt_q || (cpu_clk_q != clk_prev_q)) stall_q <= 8'h00;
        else if (stall_q != 8'hff) stall_q <= stall_q + 8'h01;
    end
    property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
    property p_rst; $past(rst) |-> main_osc_en_q && onchip_osc_en_q && !sub_osc_en_q && !pll_en_q
        && (onchip_freq_q == 4'h0) && !cpu_halt_q; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_runs; !cpu_halt_q |-> stall_q < 8'd200; endproperty
    a_runs: assert property (p_runs) else $error("processor clock stalled");
    property p_enter; $rose(cpu_halt_q) |-> $past(wait_exec, 1) || $past(wait_exec, 2); endproperty
    a_enter: assert property (p_enter) else $error("halt without wait strobe");
    property p_halt; cpu_halt_q |-> !cpu_clk_q; endproperty
    a_halt: assert property (p_halt) else $error("processor clock runs in wait");
    property p_hold; io_hold_q == cpu_halt_q; endproperty
    a_hold: assert property (p_hold) else $error("pin hold differs from wait");
    property p_osc; cpu_halt_q && $past(cpu_halt_q) |-> $stable(main_osc_en_q) && $stable(sub_osc_en_q)
        && $stable(onchip_osc_en_q); endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable moved in wait");
    property p_sub; !sub_osc_en_q && $past(!sub_osc_en_q) |-> !subclk_timer_source; endproperty
    a_sub: assert property (p_sub) else $error("sub timer clock without sub oscillator");
    // Wait entry and exit cut the processor clock outright; only source switches must be runt free
    property p_rise; $rose(cpu_clk_q) && !$fell(cpu_halt_q) |=> cpu_clk_q || cpu_halt_q; endproperty
    a_rise: assert property (p_rise) else $error("runt high pulse");
    property p_fall; $fell(cpu_clk_q) |=> !cpu_clk_q; endproperty
    a_fall: assert property (p_fall) else $error("runt low pulse");
    // Main scenarios reached
    c_wait: cover property ($rose(cpu_halt_q));
    c_bus: cover property (avs_write && !avs_waitrequest);
    c_sub: cover property ($rose(subclk_timer_source));
endmodule
bind pwc_power_mode_clock_control pwc_checker u_chk (.clk_sys(clk_sys), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .wait_exec(wait_exec), .cpu_clk_q(cpu_clk_q),
    .cpu_halt_q(cpu_halt_q), .io_hold_q(io_hold_q), .main_osc_en_q(main_osc_en_q), .sub_osc_en_q(sub_osc_en_q),
    .onchip_osc_en_q(onchip_osc_en_q), .pll_en_q(pll_en_q), .onchip_freq_q(onchip_freq_q),
    .subclk_timer_source(subclk_timer_source));
`default_nettype wire

//--- testbench.sv
// Register-level testbench of the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, wait_exec = 0, wake_req = 0;
    logic [4:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'hf, ph_q = 0, periph_clk_q, onchip_freq_q;
    logic        avs_waitrequest, cpu_clk_q, wdt_clk_q, cpu_halt_q, io_hold_q, main_osc_en_q;
    logic        subclk_timer_source;
    logic        pll_en_q, pll_mult4_q, sub_osc_en_q, serial_clock_div1, serial_clock_div32, converter_clock;
    logic [7:0]  rv [7] = '{8'h00, 8'hc0, 8'h02, 8'h00, 8'h00, 8'h05, 8'h00};
    logic [7:0]  dv [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
    int          de [4] = '{64, 32, 16, 4};
    int          n_mismatch = 0, samples_checked = 0;
    logic [31:0] q;
    always #10 clk_sys = ~clk_sys;
    // Source oscillators: main and on-chip period 8, sub 16, PLL 4
    always @(posedge clk_sys) ph_q <= ph_q + 4'h1;
    pwc_power_mode_clock_control dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .main_clk_in(ph_q[2]), .sub_clk_in(ph_q[3]), .pll_clk_in(ph_q[1]), .onchip_clk_in(~ph_q[2]),
        .wait_exec(wait_exec), .wake_req(wake_req), .cpu_clk_q(cpu_clk_q), .wdt_clk_q(wdt_clk_q),
        .cpu_halt_q(cpu_halt_q), .io_hold_q(io_hold_q), .main_osc_en_q(main_osc_en_q),
        .sub_osc_en_q(sub_osc_en_q), .onchip_osc_en_q(), .pll_en_q(pll_en_q), .pll_mult4_q(pll_mult4_q),
        .onchip_freq_q(onchip_freq_q), .periph_clk_q(periph_clk_q), .serial_clock_div1(serial_clock_div1),
        .serial_clock_div32(serial_clock_div32), .converter_clock(converter_clock),
        .subclk_timer_source(subclk_timer_source));
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_mismatch++;
            final_report();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        av(1'b0, a, 8'h00);
        check("register read", q, {24'h0, e});
    endtask
    // Count rising edges of one clock over 512 cycles after settling
    task automatic meas(input int sel, input int e);
        int n;
        logic p, v;
        n = 0;
        p = 1'b0;
        repeat (160) @(posedge clk_sys);
        repeat (512) begin
            @(posedge clk_sys);
            v = sel == 0 ? cpu_clk_q : sel == 1 ? periph_clk_q[0] : sel == 2 ? subclk_timer_source :
                sel == 3 ? wdt_clk_q : sel == 4 ? serial_clock_div32 : sel == 5 ? converter_clock :
                sel == 6 ? serial_clock_div1 : periph_clk_q[3];
            if (v === 1'b1 && p === 1'b0) n++;
            p = v;
        end
        check("clock rises", 32'(n >= e - 1 && n <= e + 1), 32'h1);
    endtask
    task automatic pulse(input logic w);
        @(posedge clk_sys);
        if (w) wait_exec <= 1'b1;
        else wake_req <= 1'b1;
        @(posedge clk_sys);
        wait_exec <= 1'b0;
        wake_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rc(5'(i * 4), rv[i]);
        meas(0, 4);
        avs_byteenable <= 4'h0;
        av(1'b1, 5'h10, 8'h8f);
        avs_byteenable <= 4'hf;
        rc(5'h10, 8'h00);
        av(1'b1, 5'h10, 8'h05);
        rc(5'h10, 8'h05);
        check("onchip freq", onchip_freq_q, 32'h5);
        av(1'b1, 5'h00, 8'h40);
        av(1'b1, 5'h08, 8'h00);
        rc(5'h14, 8'h02);
        meas(0, 8);
        av(1'b1, 5'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            av(1'b1, 5'h04, dv[i]);
            rc(5'h14, i == 0 ? 8'h01 : 8'h02);
            meas(0, de[i]);
        end
        av(1'b1, 5'h04, 8'hc2);
        rc(5'h14, 8'h12);
        av(1'b1, 5'h04, 8'h00);
        rc(5'h14, 8'h01);
        av(1'b1, 5'h0c, 8'h81);
        av(1'b1, 5'h04, 8'h02);
        rc(5'h14, 8'h00);
        check("pll control", {pll_en_q, pll_mult4_q}, 32'h3);
        meas(0, 128);
        pulse(1'b1);
        rc(5'h14, 8'h00);
        av(1'b1, 5'h04, 8'h00);
        av(1'b1, 5'h00, 8'h14);
        av(1'b1, 5'h10, 8'h80);
        pulse(1'b1);
        check("halt", {cpu_halt_q, io_hold_q, main_osc_en_q}, 32'h7);
        rc(5'h14, 8'h09);
        meas(0, 0);
        meas(1, 0);
        meas(5, 0);
        meas(2, 32);
        meas(3, 64);
        pulse(1'b0);
        check("halt", cpu_halt_q, 32'h0);
        meas(0, 64);
        av(1'b1, 5'h00, 8'h10);
        pulse(1'b1);
        meas(1, 64);
        pulse(1'b0);
        av(1'b1, 5'h00, 8'h90);
        rc(5'h14, 8'h03);
        meas(0, 32);
        meas(6, 64);
        av(1'b1, 5'h08, 8'h02);
        av(1'b1, 5'h00, 8'hb0);
        rc(5'h14, 8'h04);
        rc(5'h00, 8'hf0);
        check("main osc", main_osc_en_q, 32'h0);
        check("sub osc", sub_osc_en_q, 32'h1);
        meas(1, 0);
        meas(0, 32);
        av(1'b1, 5'h00, 8'h70);
        rc(5'h14, 8'h14);
        rc(5'h00, 8'hf0);
        av(1'b1, 5'h00, 8'hd0);
        rc(5'h14, 8'h03);
        av(1'b1, 5'h00, 8'h50);
        rc(5'h14, 8'h05);
        av(1'b1, 5'h00, 8'h70);
        rc(5'h14, 8'h06);
        meas(1, 64);
        meas(4, 2);
        meas(7, 2);
        av(1'b1, 5'h00, 8'hf0);
        rc(5'h14, 8'h16);
        final_report();
    end
endmodule
`default_nettype wire
